// file: rtl/switch_decode_defs.svh
// constants for the configuration switch decoder
// Function
// - node id is weighted sum of id switches
// - switches sampled once after power-up only
// - nonzero switch id locks out software id writes
// - all id switches off: software id used
// - ip settings writable regardless of switch id
// - recover switch at power-up restores factory ip
// - protect switch blocks firmware and configuration writes
// - report-by-exception enabled only by switch 7
// - instruction-box support enabled only by switch 7
`ifndef SWITCH_DECODE_DEFS_SVH
`define SWITCH_DECODE_DEFS_SVH

// ************************************************
// switch positions
// ************************************************
`define SW_POS_PROTECT 5
`define SW_POS_RECOVER 6
`define SW_POS_FEATURE 7
`define ID_WIDTH 6
// 1: position 5 is the protect switch and leaves the id field
`define PROTECT_LAYOUT 1'b0

// ************************************************
// register map, byte addresses
// ************************************************
`define REG_SWITCH 5'h00
`define REG_NODE_ID 5'h04
`define REG_IP 5'h08
`define REG_FIRMWARE 5'h0c
`define REG_REJECT 5'h10

// ************************************************
// reset values and timing
// ************************************************
`define NODE_ID_RESET 6'h00
`define IP_FACTORY 32'h0000_0000
`define SETTLE_CYCLES 2'h2

`endif

// file: rtl/switch_decode_pkg.sv
// types shared by the configuration switch decoder
package switch_decode_pkg;
	typedef enum logic [2:0] {
		ST_SETTLE = 3'b001,
		ST_LATCH = 3'b010,
		ST_RUN = 3'b100
	} load_state_type;
	typedef logic [5:0] node_id_type;
	typedef logic [7:0] switch_type;
endpackage

// file: rtl/node_identifier_switch_decode.sv
// power-up switch decoder with avalon-mm register slave
`timescale 1ns/100ps
`default_nettype none
`include "switch_decode_defs.svh"

module node_identifier_switch_decode (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire switch_decode_pkg::switch_type switch_in,
	input wire logic [4:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	output switch_decode_pkg::node_id_type node_identifier_out,
	output logic report_by_exception_enable_out,
	output logic instruction_box_enable_out,
	output logic write_protect_out,
	output logic config_valid_out,
	output logic [31:0] ip_settings_out,
	output logic [31:0] firmware_word_out,
	output logic firmware_strobe_out
);
	import switch_decode_pkg::*;

	// ************************************************
	// functions
	// ************************************************
	function automatic node_id_type id_sum(input switch_type sw);
		node_id_type acc;
		acc = 6'h00;
		for (int i = 0; i < `ID_WIDTH; i++) begin
			// protect position leaves the field on that layout
			if (sw[i] && !(`PROTECT_LAYOUT && i == `SW_POS_PROTECT)) begin
				acc = acc + node_id_type'(1 << i);
			end
		end
		return acc;
	endfunction

	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return res;
	endfunction

	// ************************************************
	// switch synchroniser
	// ************************************************
	switch_type sw_meta_q;
	switch_type sw_sync_q;

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			sw_meta_q <= 8'h00;
			sw_sync_q <= 8'h00;
		end else begin
			sw_meta_q <= switch_in;
			sw_sync_q <= sw_meta_q;
		end
	end

	// ************************************************
	// power-up capture
	// ************************************************
	load_state_type state_q, state_d;
	logic [1:0] settle_q, settle_d;
	switch_type sw_cap_q, sw_cap_d;

	always_comb begin
		state_d = state_q;
		settle_d = settle_q;
		sw_cap_d = sw_cap_q;
		case (state_q)
			ST_SETTLE: begin
				// reset flops of the synchroniser must flush first
				settle_d = settle_q + 2'h1;
				if (settle_q == `SETTLE_CYCLES) begin
					state_d = ST_LATCH;
				end
			end
			ST_LATCH: begin
				sw_cap_d = sw_sync_q;
				state_d = ST_RUN;
			end
			ST_RUN: begin
				state_d = ST_RUN;
			end
			default: begin
				state_d = ST_SETTLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			state_q <= ST_SETTLE;
			settle_q <= 2'h0;
			sw_cap_q <= 8'h00;
		end else begin
			state_q <= state_d;
			settle_q <= settle_d;
			sw_cap_q <= sw_cap_d;
		end
	end

	// ************************************************
	// decoded switches
	// ************************************************
	logic run;
	node_id_type sw_id;
	logic id_locked;
	logic protect;

	assign run = (state_q == ST_RUN);
	assign sw_id = id_sum(sw_cap_q);
	assign id_locked = (sw_id != 6'h00);
	assign protect = `PROTECT_LAYOUT & sw_cap_q[`SW_POS_PROTECT];

	// ************************************************
	// avalon-mm slave
	// ************************************************
	logic ack_q, ack_d;
	logic req;
	logic take;
	logic wr_node, wr_ip, wr_fw, wr_rej;
	logic [31:0] rd_q, rd_d;
	node_id_type soft_id_q, soft_id_d;
	node_id_type node_q, node_d;
	logic [31:0] ip_q, ip_d;
	logic [31:0] fw_q, fw_d;
	logic fw_stb_q, fw_stb_d;
	logic [1:0] rej_q, rej_d;
	logic [31:0] merged_node;

	assign req = avs_read_in | avs_write_in;
	// one wait cycle per access, stalled until the switches are captured
	assign avs_waitrequest_out = req & ~ack_q;
	assign take = avs_write_in & ack_q;
	assign wr_node = take & (avs_address_in == `REG_NODE_ID);
	assign wr_ip = take & (avs_address_in == `REG_IP);
	assign wr_fw = take & (avs_address_in == `REG_FIRMWARE);
	assign wr_rej = take & (avs_address_in == `REG_REJECT);
	assign merged_node = be_merge({26'h0, soft_id_q}, avs_writedata_in, avs_byteenable_in);

	always_comb begin
		ack_d = req & ~ack_q & run;
		rd_d = rd_q;
		soft_id_d = soft_id_q;
		ip_d = ip_q;
		fw_d = fw_q;
		fw_stb_d = 1'b0;
		rej_d = rej_q;
		if (state_q == ST_LATCH && sw_sync_q[`SW_POS_RECOVER]) begin
			ip_d = `IP_FACTORY;
		end
		if (wr_rej) begin
			rej_d = rej_q & ~avs_writedata_in[1:0];
		end
		if (wr_node) begin
			if (id_locked || protect) begin
				rej_d[0] = 1'b1;
			end else begin
				soft_id_d = merged_node[5:0];
			end
		end
		if (wr_ip) begin
			if (protect) begin
				rej_d[1] = 1'b1;
			end else begin
				ip_d = be_merge(ip_q, avs_writedata_in, avs_byteenable_in);
			end
		end
		if (wr_fw) begin
			if (protect) begin
				rej_d[1] = 1'b1;
			end else begin
				fw_d = be_merge(fw_q, avs_writedata_in, avs_byteenable_in);
				fw_stb_d = 1'b1;
			end
		end
		// switch id wins; zero hands the id to software
		node_d = run ? (id_locked ? sw_id : soft_id_q) : 6'h00;
		if (ack_d && avs_read_in) begin
			case (avs_address_in)
				`REG_SWITCH: rd_d = {23'h0, run, sw_cap_q};
				`REG_NODE_ID: rd_d = {23'h0, id_locked, 2'h0, node_q};
				`REG_IP: rd_d = ip_q;
				`REG_FIRMWARE: rd_d = fw_q;
				`REG_REJECT: rd_d = {30'h0, rej_q};
				default: rd_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			ack_q <= 1'b0;
			rd_q <= 32'h0000_0000;
			soft_id_q <= `NODE_ID_RESET;
			node_q <= 6'h00;
			// ip settings outlive power-up; only the recover switch clears them
			ip_q <= ip_q;
			fw_q <= 32'h0000_0000;
			fw_stb_q <= 1'b0;
			rej_q <= 2'h0;
		end else begin
			ack_q <= ack_d;
			rd_q <= rd_d;
			soft_id_q <= soft_id_d;
			node_q <= node_d;
			ip_q <= ip_d;
			fw_q <= fw_d;
			fw_stb_q <= fw_stb_d;
			rej_q <= rej_d;
		end
	end

	// ************************************************
	// outputs
	// ************************************************
	assign avs_readdata_out = rd_q;
	assign node_identifier_out = node_q;
	// capture register is zero until the latch, so no gating needed
	assign report_by_exception_enable_out = sw_cap_q[`SW_POS_FEATURE];
	assign instruction_box_enable_out = sw_cap_q[`SW_POS_FEATURE];
	assign write_protect_out = protect;
	assign config_valid_out = run;
	assign ip_settings_out = ip_q;
	assign firmware_word_out = fw_q;
	assign firmware_strobe_out = fw_stb_q;

	// ************************************************
	// assertions
	// ************************************************
	AST_ID_SUM: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		run && id_locked |=> node_identifier_out == $past(sw_id))
		else $error("node id differs from switch weight sum");

	AST_FIELD: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		run |-> sw_id == {!`PROTECT_LAYOUT & sw_cap_q[`SW_POS_PROTECT], sw_cap_q[4:0]})
		else $error("function switch counted in node id");

	AST_HOLD: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		run |=> $stable(sw_cap_q) && run)
		else $error("captured switches changed after power-up");

	AST_ID_LOCK: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		wr_node && id_locked |=> $stable(soft_id_q) && rej_q[0])
		else $error("software id changed while switch id set");

	AST_SOFT_ID: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		run && !id_locked ##1 run |-> node_identifier_out == $past(soft_id_q))
		else $error("software id not used with switches off");

	AST_IP_OPEN: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		wr_ip && !protect && avs_byteenable_in == 4'hf
		|=> ip_settings_out == $past(avs_writedata_in))
		else $error("ip write lost");

	AST_RECOVER: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		state_q == ST_LATCH && sw_sync_q[`SW_POS_RECOVER] |=> ip_q == `IP_FACTORY)
		else $error("recover did not restore factory ip");

	AST_PROTECT: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		protect && (wr_fw || wr_ip) |=> !firmware_strobe_out && $stable(ip_q) && rej_q[1])
		else $error("write passed while protected");

	AST_FEATURE: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		state_q == ST_LATCH
		|=> report_by_exception_enable_out == $past(sw_sync_q[`SW_POS_FEATURE])
		&& instruction_box_enable_out == $past(sw_sync_q[`SW_POS_FEATURE]))
		else $error("feature enable not tied to switch 7");

	AST_FEATURE_OFF: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		!run |-> !report_by_exception_enable_out && !instruction_box_enable_out)
		else $error("feature enabled before switch capture");

	AST_IP_KEEP: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		state_q == ST_LATCH && !sw_sync_q[`SW_POS_RECOVER] |=> $stable(ip_q))
		else $error("ip settings lost without recover switch");

	AST_ANSWER: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		run && req && !ack_q |=> !avs_waitrequest_out)
		else $error("slave did not answer in one cycle");

	AST_STALL: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		!run && req |-> avs_waitrequest_out)
		else $error("request answered before switch capture");

	AST_FW_WRITE: assert property (@(posedge clk_sys_in) disable iff (reset_in)
		wr_fw && !protect && avs_byteenable_in == 4'hf
		|=> firmware_strobe_out && firmware_word_out == $past(avs_writedata_in))
		else $error("firmware write lost");

endmodule // node_identifier_switch_decode
`default_nettype wire

// file: tb/node_identifier_switch_decode_tb.sv
// register-level bench for the power-up switch decoder
`timescale 1ns/100ps
`default_nettype none
`include "switch_decode_defs.svh"

module node_identifier_switch_decode_tb;
	import switch_decode_pkg::*;
	logic clk_sys_in, reset_in, avs_read_in, avs_write_in;
	switch_type switch_in;
	logic [4:0] avs_address_in;
	logic [31:0] avs_writedata_in, rdata, q;
	logic [3:0] avs_byteenable_in;
	logic wait_out, rpt_exc, instr_box, prot, valid, strobe;
	node_id_type node_id;
	logic [31:0] ip, fw;
	int fail_count, checks_done;

	node_identifier_switch_decode dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
		.switch_in(switch_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
		.avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(rdata),
		.avs_waitrequest_out(wait_out), .node_identifier_out(node_id),
		.report_by_exception_enable_out(rpt_exc), .instruction_box_enable_out(instr_box),
		.write_protect_out(prot), .config_valid_out(valid), .ip_settings_out(ip),
		.firmware_word_out(fw), .firmware_strobe_out(strobe));

	// ************************************************
	// tasks
	// ************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// called just after a rising edge; one idle edge follows so calls may chain
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_read_in <= !wr;
		avs_write_in <= wr;
		avs_address_in <= a;
		avs_writedata_in <= d;
		@(posedge clk_sys_in);
		while (wait_out !== 1'b0 && n < 50) begin
			n++;
			@(posedge clk_sys_in);
		end
		if (n >= 50) chk(32'h1, 32'h0);
		q = rdata;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
		@(posedge clk_sys_in);
	endtask

	task automatic power_up(input switch_type sw);
		int n;
		reset_in <= 1'b1;
		switch_in <= sw;
		repeat (6) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		n = 0;
		while (valid !== 1'b1 && n < 30) begin
			n++;
			@(posedge clk_sys_in);
		end
		// effective id registers one edge after the capture
		@(posedge clk_sys_in);
		chk({31'h0, valid}, 32'h1);
	endtask

	// ************************************************
	// clock, watchdog
	// ************************************************
	initial begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end

	// whole sequence needs well under 1000 cycles
	initial begin
		repeat (5000) @(posedge clk_sys_in);
		fail_count++;
		end_sim();
	end

	// ************************************************
	// tests
	// ************************************************
	initial begin
		fail_count = 0;
		checks_done = 0;
		reset_in = 1'b1;
		switch_in = 8'hce;
		avs_read_in = 1'b0;
		avs_write_in = 1'b0;
		avs_address_in = 5'h00;
		avs_writedata_in = 32'h0;
		avs_byteenable_in = 4'hf;
		@(posedge clk_sys_in);
		// id 14 from positions 1..3, recover and feature switches on
		power_up(8'hce);
		chk({26'h0, node_id}, 32'he);
		chk({30'h0, rpt_exc, instr_box}, 32'h3);
		chk({31'h0, prot}, 32'h0);
		chk(ip, `IP_FACTORY);
		switch_in <= 8'h01;
		repeat (8) @(posedge clk_sys_in);
		chk({26'h0, node_id}, 32'he);
		bus(1'b0, `REG_SWITCH, 32'h0);
		chk(q, 32'h1ce);
		bus(1'b1, `REG_NODE_ID, 32'h5);
		chk({26'h0, node_id}, 32'he);
		bus(1'b0, `REG_NODE_ID, 32'h0);
		chk(q, 32'h10e);
		bus(1'b0, `REG_REJECT, 32'h0);
		chk(q & 32'h1, 32'h1);
		bus(1'b1, `REG_REJECT, 32'h3);
		bus(1'b0, `REG_REJECT, 32'h0);
		chk(q, 32'h0);
		bus(1'b1, `REG_IP, 32'hc0a8_6405);
		chk(ip, 32'hc0a8_6405);
		bus(1'b0, `REG_IP, 32'h0);
		chk(q, 32'hc0a8_6405);
		bus(1'b1, `REG_FIRMWARE, 32'h1234_abcd);
		chk({31'h0, strobe}, 32'h1);
		@(posedge clk_sys_in);
		chk({31'h0, strobe}, 32'h0);
		chk(fw, 32'h1234_abcd);
		bus(1'b0, 5'h14, 32'h0);
		chk(q, 32'h0);
		// all id switches off, recover on, feature off
		power_up(8'h40);
		chk({26'h0, node_id}, 32'h0);
		chk({30'h0, rpt_exc, instr_box}, 32'h0);
		chk(ip, `IP_FACTORY);
		bus(1'b1, `REG_NODE_ID, 32'h2d);
		// effective id registers one edge after the software id
		@(posedge clk_sys_in);
		chk({26'h0, node_id}, 32'h2d);
		bus(1'b0, `REG_NODE_ID, 32'h0);
		chk(q, 32'h2d);
		bus(1'b1, `REG_IP, 32'h0a00_0001);
		chk(ip, 32'h0a00_0001);
		avs_byteenable_in <= 4'h3;
		bus(1'b1, `REG_IP, 32'hffff_1234);
		chk(ip, 32'h0a00_1234);
		avs_byteenable_in <= 4'hf;
		// every id position plus feature position; recover off keeps the ip
		power_up(8'hbf);
		chk({26'h0, node_id}, 32'h3f);
		chk({30'h0, rpt_exc, instr_box}, 32'h3);
		chk(ip, 32'h0a00_1234);
		power_up(8'h81);
		chk({26'h0, node_id}, 32'h1);
		// request made straight after reset stalls until the capture
		reset_in <= 1'b1;
		switch_in <= 8'h2a;
		repeat (6) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		bus(1'b0, `REG_SWITCH, 32'h0);
		chk(q, 32'h12a);
		chk({26'h0, node_id}, 32'h2a);
		end_sim();
	end
endmodule // node_identifier_switch_decode_tb
`default_nettype wire
